// File: bench/csm_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module csm_sensor_model
  import csm_pkg::*;
#(
  parameter logic [7:0] MSRC = 8'h21,
  parameter logic [7:0] MOFS = 8'h05,
  parameter logic [7:0] SSRC = 8'h22,
  parameter logic [7:0] SOFS = 8'h06
) (
  input  wire logic pclk,
  output logic        rx_valid,
  output logic [7:0]  rx_src_addr,
  output logic [7:0]  rx_group_ofs,
  output logic        rx_redundant,
  output logic [7:0]  rx_seq,
  output logic        rx_crc_ok,
  output logic [15:0] rx_value,
  output logic [1:0]  rx_dir
);
  // ----------------------------------------
  // four ecu channels: angle/speed x prim/red
  // ----------------------------------------
  logic [7:0] seq_q [4];
  // offsets belong to this node only
  // sends as soon as asked, well inside power-up grace
  initial begin
    rx_valid = 1'b0;
    {rx_src_addr, rx_group_ofs, rx_redundant, rx_seq} = '0;
    {rx_crc_ok, rx_value, rx_dir} = '0;
    for (int i = 0; i < 4; i++) seq_q[i] = 8'hfd;
  end
  // kind 0 angle, 1 speed, 2 foreign node
  task automatic send(input int kind, input logic red, input logic skip,
                      input logic crc, input logic [15:0] val, input logic [1:0] dir);
    int c;
    c = (kind % 2) * 2 + int'(red);
    if (kind < 2) seq_q[c] = seq_q[c] + (skip ? 8'h02 : 8'h01);
    @(posedge pclk);
    rx_valid     <= 1'b1;
    rx_src_addr  <= (kind == 0) ? MSRC : (kind == 1) ? SSRC : 8'h7e;
    rx_group_ofs <= (kind == 0) ? MOFS : (kind == 1) ? SOFS : 8'h7e;
    rx_redundant <= red;
    rx_seq       <= seq_q[c];
    rx_crc_ok    <= crc;
    rx_value     <= val;
    rx_dir       <= dir;
    @(posedge pclk);
    // released lines float: show the inverse, never the last value
    rx_valid     <= 1'b0;
    rx_src_addr  <= ~rx_src_addr;
    rx_group_ofs <= ~rx_group_ofs;
    rx_redundant <= ~rx_redundant;
    rx_seq       <= ~rx_seq;
    rx_crc_ok    <= ~rx_crc_ok;
    rx_value     <= ~rx_value;
    rx_dir       <= ~rx_dir;
  endtask : send
endmodule : csm_sensor_model
`default_nettype wire

// File: bench/tb_dual_channel_can_sensor_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_channel_can_sensor_monitor
  import csm_pkg::*;
;
  localparam logic [7:0]  MSRC = 8'h21;
  localparam logic [7:0]  MOFS = 8'h05;
  localparam logic [7:0]  SSRC = 8'h22;
  localparam logic [7:0]  SOFS = 8'h06;
  localparam logic [31:0] SAFE = 32'h0001_0000;
  localparam int          FK [6] = '{0, 1, 0, 1, 1, 0};
  localparam int          FB [6] = '{CSM_F_MCRC, CSM_F_SSEQ, CSM_F_MRNG,
                                     CSM_F_SRNG, CSM_F_SDIR, CSM_F_MCRC};
  localparam logic [15:0] FV [6] = '{16'd0, 16'd10, 16'd101, 16'd201, 16'd10, 16'd0};
  localparam logic [5:0]  FR = 6'b100010;
  localparam logic [5:0]  FS = 6'b000010;
  localparam logic [5:0]  FC = 6'b011110;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, safe_state;
  logic [7:0]  paddr, rx_src_addr, rx_group_ofs, rx_seq;
  logic [31:0] pwdata, prdata, rd;
  logic        rx_valid, rx_redundant, rx_crc_ok, er;
  logic [15:0] rx_value;
  logic [1:0]  rx_dir;
  int          miscompares = 0;
  int          compares = 0;

  csm_monitor #(.TICK_CYC(10)) csm_monitor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_src_addr(rx_src_addr), .rx_group_ofs(rx_group_ofs),
    .rx_redundant(rx_redundant), .rx_seq(rx_seq), .rx_crc_ok(rx_crc_ok),
    .rx_value(rx_value), .rx_dir(rx_dir), .safe_state(safe_state));

  csm_sensor_model #(.MSRC(MSRC), .MOFS(MOFS), .SSRC(SSRC), .SOFS(SOFS)) csm_sensor_model_i (
    .pclk(pclk), .rx_valid(rx_valid), .rx_src_addr(rx_src_addr),
    .rx_group_ofs(rx_group_ofs), .rx_redundant(rx_redundant), .rx_seq(rx_seq),
    .rx_crc_ok(rx_crc_ok), .rx_value(rx_value), .rx_dir(rx_dir));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) miscompares++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rst();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst

  // timeouts far above the gaps these tests leave between frames
  task automatic cfg(input logic [7:0] mt, input logic [7:0] st, input logic role);
    rst();
    apb(1'b1, CSM_MASTER_ID_OFS, {16'h0, MOFS, MSRC});
    apb(1'b1, CSM_SPEED_ID_OFS, {16'h0, SOFS, SSRC});
    apb(1'b1, CSM_MASTER_LIM_OFS, 32'h0002_0005);
    apb(1'b1, CSM_SPEED_LIM_OFS, 32'h0002_0005);
    apb(1'b1, CSM_TIMEOUT_OFS, {16'h0, st, mt});
    apb(1'b1, CSM_ANGLE_RANGE_OFS, 32'h0064_ff9c);
    apb(1'b1, CSM_SPEED_RANGE_OFS, 32'h00c8_0000);
    apb(1'b1, CSM_CTRL_OFS, {30'h0, role, 1'b1});
  endtask : cfg

  task automatic status(input logic [31:0] exp);
    apb(1'b0, CSM_STATUS_OFS, 32'h0);
    chk(rd, exp);
  endtask : status

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rst();
    apb(1'b0, CSM_TIMEOUT_OFS, 32'h0);
    chk(rd, CSM_TIMEOUT_RST);
    apb(1'b0, CSM_ANGLE_RANGE_OFS, 32'h0);
    chk(rd, CSM_RANGE_RST);
    apb(1'b0, CSM_SPEED_RANGE_OFS, 32'h0);
    chk(rd, CSM_RANGE_RST);
    apb(1'b1, 8'h24, 32'h1);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, CSM_STATUS_OFS, 32'hffff_ffff);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, CSM_MASTER_ID_OFS, 32'h0000_a55a);
    apb(1'b0, CSM_MASTER_ID_OFS, 32'h0);
    chk(rd, 32'h0000_a55a);
    chk({31'h0, er}, 32'h0);
    // matching key but monitor still disabled: bad frame must be ignored
    apb(1'b1, CSM_MASTER_ID_OFS, {16'h0, MOFS, MSRC});
    csm_sensor_model_i.send(0, 1'b0, 1'b0, 1'b0, 16'd0, CSM_DIR_FWD);
    status(32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_clean();
    cfg(8'hff, 8'hff, 1'b0);
    for (int i = 0; i < 16; i++)
      csm_sensor_model_i.send(i % 2, (i / 2) % 2 == 1, 1'b0, 1'b1, 16'd10, CSM_DIR_FWD);
    csm_sensor_model_i.send(2, 1'b0, 1'b0, 1'b0, 16'hffff, CSM_DIR_ERR);
    repeat (3) @(posedge pclk);
    status(32'h0);
    chk({31'h0, safe_state}, 32'h0);
    $display("test clean done");
  endtask : t_clean

  task automatic t_fault();
    for (int k = 0; k < 6; k++) begin
      cfg(8'hff, 8'hff, k % 2 == 1);
      csm_sensor_model_i.send(FK[k], FR[k], 1'b0, 1'b1, FK[k] != 0 ? 16'd200 : 16'd100,
                              CSM_DIR_FWD);
      csm_sensor_model_i.send(FK[k], FR[k], FS[k], FC[k], FV[k],
                              (k == 4) ? CSM_DIR_ERR : CSM_DIR_FWD);
      repeat (3) @(posedge pclk);
      chk({31'h0, safe_state}, 32'h1);
      status(SAFE | (32'h1 << FB[k]));
      csm_sensor_model_i.send(FK[k], FR[k], 1'b0, 1'b1, 16'd5, CSM_DIR_FWD);
      repeat (3) @(posedge pclk);
      status(SAFE | (32'h1 << FB[k]));
    end
    $display("test fault done");
  endtask : t_fault

  task automatic t_tmo();
    for (int j = 0; j < 2; j++) begin
      cfg(j == 1 ? 8'hff : 8'h02, j == 1 ? 8'h02 : 8'hff, 1'b0);
      repeat (10) @(posedge pclk);
      status(32'h0);
      repeat (40) @(posedge pclk);
      status(SAFE | (32'h1 << (j == 1 ? CSM_F_STMO : CSM_F_MTMO)));
    end
    $display("test timeout done");
  endtask : t_tmo

  task automatic t_diff(input int kd, input logic [15:0] pv, input logic [1:0] pd,
                        input logic [15:0] rv, input logic [1:0] rdir, input logic [31:0] exp);
    csm_sensor_model_i.send(kd, 1'b0, 1'b0, 1'b1, pv, pd);
    csm_sensor_model_i.send(kd, 1'b1, 1'b0, 1'b1, rv, rdir);
    repeat (60) @(posedge pclk);
    status(exp);
    $display("test diff done");
  endtask : t_diff

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (10000) @(posedge pclk);
    miscompares++;
    give_verdict();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    t_regs();
    t_clean();
    t_fault();
    t_tmo();
    cfg(8'hff, 8'hff, 1'b0);
    t_diff(0, 16'd2, CSM_DIR_FWD, 16'hfffd, CSM_DIR_FWD, 32'h0);
    t_diff(0, 16'd2, CSM_DIR_FWD, 16'hfffc, CSM_DIR_FWD, SAFE | (32'h1 << CSM_F_MDIFF));
    cfg(8'hff, 8'hff, 1'b1);
    t_diff(1, 16'd50, CSM_DIR_FWD, 16'd52, CSM_DIR_NA, 32'h0);
    t_diff(1, 16'd50, CSM_DIR_FWD, 16'd50, CSM_DIR_REV, SAFE | (32'h1 << CSM_F_SDIFF));
    give_verdict();
  end
endmodule : tb_dual_channel_can_sensor_monitor
`default_nettype wire

// File: verilog/csm_chan_watch.sv
`timescale 1ns/1ps
`default_nettype none
module csm_chan_watch
  import csm_pkg::*;
#(
  parameter int CW = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          enable,
  input  wire logic          tick,
  input  wire logic          rx_valid,
  input  wire logic [7:0]    rx_seq,
  input  wire logic [CW-1:0] timeout,
  output logic               tmo_fault,
  output logic               seq_fault
);

  logic [CW-1:0] gap_q, gap_d;
  logic [7:0]    seq_q, seq_d;
  logic          seen_q, seen_d;
  logic          tmo_q, tmo_d, sq_q, sq_d;

  // gap counter restarts on every message; first message only arms the sequence
  always_comb begin
    gap_d  = gap_q;
    seq_d  = seq_q;
    seen_d = seen_q;
    tmo_d  = 1'b0;
    sq_d   = 1'b0;
    if (enable) begin
      if (rx_valid) begin
        gap_d  = '0;
        seq_d  = rx_seq;
        seen_d = 1'b1;
        sq_d   = seen_q && (rx_seq != seq_q + 8'h01);
      end else if (tick) begin
        if (gap_q >= timeout)
          tmo_d = 1'b1;
        else
          gap_d = gap_q + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q  <= '0;
      seq_q  <= 8'h00;
      seen_q <= 1'b0;
      tmo_q  <= 1'b0;
      sq_q   <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      seq_q  <= seq_d;
      seen_q <= seen_d;
      tmo_q  <= tmo_d;
      sq_q   <= sq_d;
    end
  end

  assign tmo_fault = tmo_q;
  assign seq_fault = sq_q;

endmodule : csm_chan_watch
`default_nettype wire

// File: verilog/csm_monitor.sv
// Functional notes
// [R1] main takes primary angle, safety takes redundant; the role bit only sets own, which drives nothing
// [R2] sensors start sending within ten seconds
// [R3] angle message gap over timeout forces safe
// [R4] sequence mismatch forces safe state
// [R5] CRC failure forces safe state
// [R6] out-of-range wheel angle forces safe
// [R7] persistent angle divergence forces safe state
// [R8] angle timeout set to 1.5 periods
// [R9] angle group offset differs per controller
// [R10] every check applies to both channels
// [R11] angle messages matched by address, offset
// [R12] main takes primary speed, safety redundant; the role bit only sets own, which drives nothing
// [R13] out-of-range speed forces safe state
// [R14] direction error code forces safe state
// [R15] direction not-available treated as forward
// [R16] direction gives sign of speed
// [R17] persistent speed divergence forces safe state
// [R18] speed message gap over timeout forces safe
// [R19] speed group offset differs per controller
// [R20] speed messages matched by address, offset
// [R21] safe state latched until reset
`timescale 1ns/1ps
`default_nettype none
module csm_monitor
  import csm_pkg::*;
#(
  parameter int TICK_CYC = CSM_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_src_addr,
  input  wire logic [7:0]  rx_group_ofs,
  input  wire logic        rx_redundant,
  input  wire logic [7:0]  rx_seq,
  input  wire logic        rx_crc_ok,
  input  wire logic [15:0] rx_value,
  input  wire logic [1:0]  rx_dir,
  output logic             safe_state
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d, mid_q, mid_d, sid_q, sid_d, mlim_q, mlim_d;
  logic [31:0] slim_q, slim_d, tmo_q, tmo_d, arng_q, arng_d, srng_q, srng_d;
  logic [CSM_NFAULT-1:0] flt_q, flt_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic        rdy_q, rdy_d;

  // writes land only at the edge that completes the transfer
  wire logic acc = psel && penable;
  wire logic wr  = acc && pwrite && rdy_q;
  wire logic en  = ctrl_q[CSM_CTRL_EN_BIT];

  // ------------------------------------------------------------
  // message match and channel selection
  // ------------------------------------------------------------
  // own channel follows controller role but feeds no check; both channels are checked alike
  wire logic own = rx_redundant == ctrl_q[CSM_CTRL_SAFETY_BIT]; // [R1] [R12]
  wire logic m_hit = rx_valid && rx_src_addr == mid_q[CSM_LO8+:8]
                   && rx_group_ofs == mid_q[CSM_HI8+:8]; // [R11]
  wire logic s_hit = rx_valid && rx_src_addr == sid_q[CSM_LO8+:8]
                   && rx_group_ofs == sid_q[CSM_HI8+:8]; // [R20]

  logic [TICK_CYC > 1 ? $clog2(TICK_CYC)-1 : 0 : 0] pre_q, pre_d;
  wire logic tick = pre_q == '0;

  // ------------------------------------------------------------
  // per-channel timing and sequence checks
  // ------------------------------------------------------------
  logic [CSM_NCH-1:0] m_tmo, m_seq, s_tmo, s_seq;
  genvar g;
  generate
    for (g = 0; g < CSM_NCH; g++) begin : g_ch // [R10]
      csm_chan_watch #(.CW(8)) u_m ( // [R3] [R4]
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (en),
        .tick      (tick),
        .rx_valid  (m_hit && rx_redundant == 1'(g)),
        .rx_seq    (rx_seq),
        .timeout   (tmo_q[CSM_LO8+:8]),
        .tmo_fault (m_tmo[g]),
        .seq_fault (m_seq[g])
      );
      csm_chan_watch #(.CW(8)) u_s ( // [R18] [R4]
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (en),
        .tick      (tick),
        .rx_valid  (s_hit && rx_redundant == 1'(g)),
        .rx_seq    (rx_seq),
        .timeout   (tmo_q[CSM_HI8+:8]),
        .tmo_fault (s_tmo[g]),
        .seq_fault (s_seq[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // value capture and cross-check
  // ------------------------------------------------------------
  logic signed [15:0] ang_q [CSM_NCH], ang_d [CSM_NCH];
  logic signed [16:0] spd_q [CSM_NCH], spd_d [CSM_NCH];
  logic [15:0] mdt_q, mdt_d, sdt_q, sdt_d;
  logic signed [17:0] adiff, sdiff;
  logic [17:0] aabs, sabs;
  logic signed [16:0] sgn_spd;
  logic rng_a, rng_s;

  always_comb begin
    // not-available and forward both give positive sign
    sgn_spd = (rx_dir == CSM_DIR_REV) ? -$signed({1'b0, rx_value})
                                      : $signed({1'b0, rx_value}); // [R15] [R16]
    rng_a = $signed(rx_value) < $signed(arng_q[CSM_LO8+:16])
         || $signed(rx_value) > $signed(arng_q[CSM_HI16+:16]);
    rng_s = rx_value < srng_q[CSM_LO8+:16] || rx_value > srng_q[CSM_HI16+:16];
    for (int i = 0; i < CSM_NCH; i++) begin
      ang_d[i] = ang_q[i];
      spd_d[i] = spd_q[i];
      if (m_hit && rx_redundant == i[0])
        ang_d[i] = $signed(rx_value);
      if (s_hit && rx_redundant == i[0])
        spd_d[i] = sgn_spd;
    end
    adiff = 18'(ang_q[0]) - 18'(ang_q[1]);
    sdiff = 18'(spd_q[0]) - 18'(spd_q[1]);
    aabs  = adiff[17] ? 18'(-adiff) : 18'(adiff);
    sabs  = sdiff[17] ? 18'(-sdiff) : 18'(sdiff);
    // divergence timers count ticks while above limit, reset when back inside
    mdt_d = mdt_q;
    sdt_d = sdt_q;
    if (!en || aabs <= 18'(mlim_q[CSM_LO8+:16]))
      mdt_d = '0;
    else if (tick && mdt_q != 16'hffff)
      mdt_d = mdt_q + 16'h0001; // [R7]
    if (!en || sabs <= 18'(slim_q[CSM_LO8+:16]))
      sdt_d = '0;
    else if (tick && sdt_q != 16'hffff)
      sdt_d = sdt_q + 16'h0001; // [R17]
  end

  // ------------------------------------------------------------
  // fault latch and bus
  // ------------------------------------------------------------
  always_comb begin
    flt_d = flt_q; // [R21]
    if (en) begin
      flt_d[CSM_F_MTMO]  = flt_q[CSM_F_MTMO] | (|m_tmo); // [R3]
      flt_d[CSM_F_MSEQ]  = flt_q[CSM_F_MSEQ] | (|m_seq); // [R4]
      flt_d[CSM_F_STMO]  = flt_q[CSM_F_STMO] | (|s_tmo); // [R18]
      flt_d[CSM_F_SSEQ]  = flt_q[CSM_F_SSEQ] | (|s_seq); // [R4]
      flt_d[CSM_F_MCRC]  = flt_q[CSM_F_MCRC] | (m_hit && !rx_crc_ok); // [R5]
      flt_d[CSM_F_SCRC]  = flt_q[CSM_F_SCRC] | (s_hit && !rx_crc_ok); // [R5]
      flt_d[CSM_F_MRNG]  = flt_q[CSM_F_MRNG] | (m_hit && rng_a); // [R6]
      flt_d[CSM_F_SRNG]  = flt_q[CSM_F_SRNG] | (s_hit && rng_s); // [R13]
      flt_d[CSM_F_SDIR]  = flt_q[CSM_F_SDIR] | (s_hit && rx_dir == CSM_DIR_ERR); // [R14]
      flt_d[CSM_F_MDIFF] = flt_q[CSM_F_MDIFF] | (mdt_q > mlim_q[CSM_HI16+:16]); // [R7]
      flt_d[CSM_F_SDIFF] = flt_q[CSM_F_SDIFF] | (sdt_q > slim_q[CSM_HI16+:16]); // [R17]
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    mid_d  = mid_q;
    sid_d  = sid_q;
    mlim_d = mlim_q;
    slim_d = slim_q;
    tmo_d  = tmo_q;
    arng_d = arng_q;
    srng_d = srng_q;
    rdata_d = 32'h0000_0000;
    err_d  = 1'b0;
    rdy_d  = acc && !rdy_q;
    pre_d  = tick ? ($bits(pre_q))'(TICK_CYC - 1) : pre_q - 1'b1;
    if (acc) begin
      rdata_d = 32'h0000_0000;
      case (paddr)
        CSM_CTRL_OFS:        begin if (wr) ctrl_d = pwrite ? pwdata : ctrl_q; rdata_d = ctrl_q; end
        CSM_MASTER_ID_OFS:   begin if (wr) mid_d  = pwdata; rdata_d = mid_q;  end
        CSM_SPEED_ID_OFS:    begin if (wr) sid_d  = pwdata; rdata_d = sid_q;  end
        CSM_MASTER_LIM_OFS:  begin if (wr) mlim_d = pwdata; rdata_d = mlim_q; end
        CSM_SPEED_LIM_OFS:   begin if (wr) slim_d = pwdata; rdata_d = slim_q; end
        CSM_TIMEOUT_OFS:     begin if (wr) tmo_d  = pwdata; rdata_d = tmo_q;  end
        CSM_ANGLE_RANGE_OFS: begin if (wr) arng_d = pwdata; rdata_d = arng_q; end
        CSM_SPEED_RANGE_OFS: begin if (wr) srng_d = pwdata; rdata_d = srng_q; end
        CSM_STATUS_OFS: begin
          rdata_d = 32'(flt_q);
          rdata_d[CSM_SAFE_BIT] = |flt_q;
          err_d = pwrite;
        end
        default: err_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 32'h0000_0000;
      mid_q  <= 32'h0000_0000;
      sid_q  <= 32'h0000_0000;
      mlim_q <= 32'h0000_0000;
      slim_q <= 32'h0000_0000;
      tmo_q  <= CSM_TIMEOUT_RST;
      arng_q <= CSM_RANGE_RST;
      srng_q <= CSM_RANGE_RST;
      flt_q  <= '0;
      rdata_q <= 32'h0000_0000;
      err_q  <= 1'b0;
      rdy_q  <= 1'b0;
      pre_q  <= '0;
      mdt_q  <= '0;
      sdt_q  <= '0;
      for (int i = 0; i < CSM_NCH; i++) begin
        ang_q[i] <= '0;
        spd_q[i] <= '0;
      end
    end else begin
      ctrl_q <= ctrl_d;
      mid_q  <= mid_d;
      sid_q  <= sid_d;
      mlim_q <= mlim_d;
      slim_q <= slim_d;
      tmo_q  <= tmo_d;
      arng_q <= arng_d;
      srng_q <= srng_d;
      flt_q  <= flt_d;
      rdata_q <= rdata_d;
      err_q  <= err_d;
      rdy_q  <= rdy_d;
      pre_q  <= pre_d;
      mdt_q  <= mdt_d;
      sdt_q  <= sdt_d;
      for (int i = 0; i < CSM_NCH; i++) begin
        ang_q[i] <= ang_d[i];
        spd_q[i] <= spd_d[i];
      end
    end
  end

  // one wait state so that read data and error leave flip-flops
  assign pready     = rdy_q;
  assign prdata     = rdata_q;
  assign pslverr    = err_q;
  assign safe_state = |flt_q; // [R21]

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_bad_crc;
    en && m_hit && !rx_crc_ok;
  endsequence

  property p_crc_safe;
    @(posedge pclk) disable iff (!presetn) s_bad_crc |=> safe_state;
  endproperty
  a_crc_safe: assert property (p_crc_safe) else $error("crc fail not safe"); // [R5]

  property p_dir_err;
    @(posedge pclk) disable iff (!presetn)
      en && s_hit && rx_dir == CSM_DIR_ERR |=> flt_q[CSM_F_SDIR];
  endproperty
  a_dir_err: assert property (p_dir_err) else $error("direction error missed"); // [R14]

  property p_latch;
    @(posedge pclk) disable iff (!presetn) safe_state |=> safe_state;
  endproperty
  a_latch: assert property (p_latch) else $error("safe state released"); // [R21]

  property p_rng_a;
    @(posedge pclk) disable iff (!presetn) en && m_hit && rng_a |=> flt_q[CSM_F_MRNG];
  endproperty
  a_rng_a: assert property (p_rng_a) else $error("angle range missed"); // [R6]

  property p_rng_s;
    @(posedge pclk) disable iff (!presetn) en && s_hit && rng_s |=> flt_q[CSM_F_SRNG];
  endproperty
  a_rng_s: assert property (p_rng_s) else $error("speed range missed"); // [R13]

  property p_na_fwd;
    @(posedge pclk) disable iff (!presetn)
      s_hit && rx_dir == CSM_DIR_NA
      |=> ($past(rx_redundant) ? spd_q[1] : spd_q[0]) >= 0;
  endproperty
  a_na_fwd: assert property (p_na_fwd) else $error("n/a not forward"); // [R15]

  sequence s_rev_frame;
    s_hit && rx_dir == CSM_DIR_REV && rx_value != 16'h0000;
  endsequence

  // the channel that sent the frame must hold a negative speed
  property p_rev_sign;
    @(posedge pclk) disable iff (!presetn)
      s_rev_frame |=> ($past(rx_redundant) ? spd_q[1] : spd_q[0]) < 0;
  endproperty
  a_rev_sign: assert property (p_rev_sign) else $error("reverse not negative"); // [R16]

  property p_mdiff;
    @(posedge pclk) disable iff (!presetn) en && mdt_q > mlim_q[CSM_HI16+:16] |=> safe_state;
  endproperty
  a_mdiff: assert property (p_mdiff) else $error("angle divergence missed"); // [R7]

  property p_sdiff;
    @(posedge pclk) disable iff (!presetn) en && sdt_q > slim_q[CSM_HI16+:16] |=> safe_state;
  endproperty
  a_sdiff: assert property (p_sdiff) else $error("speed divergence missed"); // [R17]

  property p_tmo;
    @(posedge pclk) disable iff (!presetn) en && (|m_tmo || |s_tmo) |=> safe_state;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout missed"); // [R3] [R18]

endmodule : csm_monitor
`default_nettype wire

// File: verilog/csm_pkg.sv
package csm_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [7:0] CSM_CTRL_OFS        = 8'h00;
  localparam logic [7:0] CSM_MASTER_ID_OFS   = 8'h04;
  localparam logic [7:0] CSM_SPEED_ID_OFS    = 8'h08;
  localparam logic [7:0] CSM_MASTER_LIM_OFS  = 8'h0c;
  localparam logic [7:0] CSM_SPEED_LIM_OFS   = 8'h10;
  localparam logic [7:0] CSM_TIMEOUT_OFS     = 8'h14;
  localparam logic [7:0] CSM_ANGLE_RANGE_OFS = 8'h18;
  localparam logic [7:0] CSM_SPEED_RANGE_OFS = 8'h1c;
  localparam logic [7:0] CSM_STATUS_OFS      = 8'h20;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int CSM_CTRL_EN_BIT     = 0;
  localparam int CSM_CTRL_SAFETY_BIT = 1;
  localparam int CSM_LO8             = 0;
  localparam int CSM_HI8             = 8;
  localparam int CSM_HI16            = 16;

  // status bit positions, one per fault cause
  localparam int CSM_F_MTMO  = 0;
  localparam int CSM_F_MSEQ  = 1;
  localparam int CSM_F_MCRC  = 2;
  localparam int CSM_F_MRNG  = 3;
  localparam int CSM_F_MDIFF = 4;
  localparam int CSM_F_STMO  = 5;
  localparam int CSM_F_SSEQ  = 6;
  localparam int CSM_F_SCRC  = 7;
  localparam int CSM_F_SRNG  = 8;
  localparam int CSM_F_SDIR  = 9;
  localparam int CSM_F_SDIFF = 10;
  localparam int CSM_NFAULT  = 11;
  localparam int CSM_SAFE_BIT = 16;
  localparam int CSM_NCH     = 2;

  // direction field codes
  localparam logic [1:0] CSM_DIR_FWD = 2'h0;
  localparam logic [1:0] CSM_DIR_REV = 2'h1;
  localparam logic [1:0] CSM_DIR_ERR = 2'h2;
  localparam logic [1:0] CSM_DIR_NA  = 2'h3;

  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [31:0] CSM_TIMEOUT_RST = 32'h0000_4b4b;
  localparam logic [31:0] CSM_RANGE_RST   = 32'h7fff_8001;
  localparam int          CSM_CLK_HZ      = 25_000_000;
  localparam int          CSM_TICK_MS     = 10;
  localparam int          CSM_TICK_CYC    = CSM_CLK_HZ / 1000 * CSM_TICK_MS;

endpackage : csm_pkg
